/* rtl/pdv_pkg.sv */
// Constants, field layouts and threshold, receive event and state types for the PD PHY vendor register bank
package pdv_pkg;

  // Clock and timing
  localparam int CLK_MHZ      = 125;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
  localparam int BIST_CONT_US = 50000;
  localparam int BIST_CYCLES  = BIST_CONT_US * CLK_MHZ;
  localparam int TICK_W       = 17;
  localparam int BIST_W       = 23;

  // Register offsets
  localparam logic [7:0] OFS_TX_CTRL   = 8'h95;
  localparam logic [7:0] OFS_RX_CTRL   = 8'h96;
  localparam logic [7:0] OFS_RX_STAT   = 8'h97;
  localparam logic [7:0] OFS_DRAIN     = 8'h98;
  localparam logic [7:0] OFS_THERMAL   = 8'h99;
  localparam logic [7:0] OFS_TIMER_LO  = 8'hA0;
  localparam logic [7:0] OFS_TIMER_HI  = 8'hA1;
  localparam logic [7:0] REG_RESET     = 8'h00;

  // Field positions
  localparam int TXC_CONT_BIT  = 2;
  localparam int TXC_FRS_BIT   = 1;
  localparam int RXC_RSV_BIT   = 3;
  localparam int RXC_OVR_BIT   = 2;
  localparam int RXC_SEL_LSB   = 0;
  localparam int RXS_PRE_BIT   = 3;
  localparam int RXS_CRC_BIT   = 2;
  localparam int RXS_EOP_BIT   = 1;
  localparam int RXS_SOP_BIT   = 0;
  localparam int DRN_VCONN_BIT = 1;
  localparam int DRN_VBUS_BIT  = 0;
  localparam int OT_LIVE_BIT   = 4;
  localparam int OT_EN_BIT     = 0;
  localparam int VST_TIMER_BIT = 4;
  localparam int VST_OT_BIT    = 2;

  // Threshold select encodings
  localparam logic [1:0] SEL_SNK   = 2'h0;
  localparam logic [1:0] SEL_SRC   = 2'h1;
  localparam logic [1:0] SEL_NEU   = 2'h2;
  localparam logic [1:0] SEL_MIXED = 2'h3;

  typedef enum logic [1:0] {PDV_LVL_SNK, PDV_LVL_SRC, PDV_LVL_NEU} pdv_level_type;

  typedef struct packed {
    pdv_level_type high;
    pdv_level_type low;
  } pdv_thresh_type;

  typedef struct packed {
    logic preamble;
    logic sop;
    logic eop;
    logic crc_ok;
  } pdv_rx_event_type;

  typedef enum logic {PDV_TMR_IDLE, PDV_TMR_RUN} pdv_timer_state_type;
  typedef enum logic {PDV_BIST_IDLE, PDV_BIST_SEND} pdv_bist_state_type;

endpackage

/* rtl/pdv_vendor_regs.sv */
// PD PHY vendor control and status registers with tick timer
//
// Contract
// - Carrier mode 2 pattern is timed when select is 0, continuous when 1.
// - Writing fast role swap bit 1 sends a fast role swap signal.
// - Override 0 takes thresholds from power role; 1 from select field.
// - Select 00 sink, 01 source, 10 neutral, 11 sink high with source low.
// - Status bit 3 marks preamble seen, bit 0 marks start of packet.
// - Status bit 2 marks good CRC, bit 1 marks end of packet.
// - Internal cable power drain used only while control bit 1 is 0.
// - Internal bus power drain used only while control bit 0 is 0.
// - Thermal bit 4 shows live overheat detector output, read only.
// - Overheat detection enabled only while thermal bit 0 is 1; reset 0.
// - Timer low byte register is writable and resets to zero.
// - New timer value applies only on high byte write; low first.
// - Timer byte reads return last written value, not the live count.
// - A non-zero applied value starts the timer counting toward zero.
// - Reaching zero sets the timer expired flag.
// - Applying zero stops the timer and keeps it disabled.
// - Each count is one 1000 microsecond tick.
// - Timer high byte register is writable, resets to zero, applies value.
// - Expired flag is vendor status bit 4; 0 when not expired or disabled.
// - Latched overheat flag at vendor status bit 2 sets on detection.
module pdv_vendor_regs
  import pdv_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter int BIST_CYCLES_P = BIST_CYCLES
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Register access from the serial slave
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic             reg_wr_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_rd_i,
  output logic      [7:0]       reg_rdata_o,
  // Vendor status flags, write-one-clear pulses from the status block
  input  wire logic [7:0]       status_clear_i,
  output logic                  tick_timer_expired_o,
  output logic                  overheat_latched_o,
  // Transmitter
  input  wire logic             bist_carrier_start_i,
  input  wire logic             bist_carrier_stop_i,
  output logic                  bist_carrier_o,
  output logic                  frs_send_o,
  input  wire logic             frs_done_i,
  // Receiver
  input  wire logic             power_role_source_i,
  input  wire pdv_rx_event_type rx_event_i,
  output pdv_thresh_type        rx_thresh_o,
  // Discharge
  input  wire logic             vbus_drain_req_i,
  input  wire logic             vconn_drain_req_i,
  output logic                  vbus_drain_o,
  output logic                  vconn_drain_o,
  // Thermal
  input  wire logic             overheat_detector_i
);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES_P - 1);
  localparam logic [BIST_W-1:0] BIST_LAST = BIST_W'(BIST_CYCLES_P - 1);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  function automatic pdv_level_type sel_high(input logic [1:0] sel);
    case (sel)
      SEL_SRC: return PDV_LVL_SRC;
      SEL_NEU: return PDV_LVL_NEU;
      default: return PDV_LVL_SNK;
    endcase
  endfunction

  function automatic pdv_level_type sel_low(input logic [1:0] sel);
    case (sel)
      SEL_SNK: return PDV_LVL_SNK;
      SEL_NEU: return PDV_LVL_NEU;
      default: return PDV_LVL_SRC;
    endcase
  endfunction

  logic                carrier_continuous_reg;
  logic                frs_reg;
  logic                rx_threshold_override_reg;
  logic                rx_ctrl_spare_reg;
  logic [1:0]          rx_threshold_select_reg;
  logic [3:0]          rx_status_reg;
  logic                cable_power_drain_off_reg;
  logic                bus_power_drain_off_reg;
  logic                overheat_detect_on_reg;
  logic [7:0]          tick_timer_low_reg;
  logic [7:0]          tick_timer_high_reg;
  logic [7:0]          rdata_reg;
  logic                sync1_reg;
  logic                sync2_reg;
  logic                sync3_reg;
  logic                overheat_raw_reg;
  logic                overheat_latched_reg;
  logic                expired_reg;
  logic [15:0]         tick_timer_value_reg;
  logic [TICK_W-1:0]   tick_cnt_reg;
  logic [BIST_W-1:0]   bist_cnt_reg;
  pdv_timer_state_type tmr_state_reg;
  pdv_bist_state_type  bist_state_reg;
  pdv_thresh_type      thresh_reg;
  pdv_thresh_type      thresh_next;
  logic                vbus_drain_reg;
  logic                vconn_drain_reg;
  logic                overheat_live;
  logic                timer_load;
  logic [15:0]         timer_load_value;
  logic                tick;
  logic                timer_hits_zero;
  logic                frs_set;
  logic [7:0]          rdata_next;

  // Write decode
  assign frs_set          = reg_wr_i && hit(reg_addr_i, OFS_TX_CTRL)
                            && reg_wdata_i[TXC_FRS_BIT];
  assign timer_load       = reg_wr_i && hit(reg_addr_i, OFS_TIMER_HI);
  assign timer_load_value = {reg_wdata_i, tick_timer_low_reg};

  // Software control fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carrier_continuous_reg    <= 1'b0;
      rx_threshold_override_reg <= 1'b0;
      rx_ctrl_spare_reg         <= 1'b0;
      rx_threshold_select_reg   <= SEL_SNK;
      cable_power_drain_off_reg <= 1'b0;
      bus_power_drain_off_reg   <= 1'b0;
      overheat_detect_on_reg    <= 1'b0;
      tick_timer_low_reg        <= REG_RESET;
      tick_timer_high_reg       <= REG_RESET;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, OFS_TX_CTRL)) begin
        carrier_continuous_reg <= reg_wdata_i[TXC_CONT_BIT];
      end
      if (hit(reg_addr_i, OFS_RX_CTRL)) begin
        rx_threshold_override_reg <= reg_wdata_i[RXC_OVR_BIT];
        rx_ctrl_spare_reg         <= reg_wdata_i[RXC_RSV_BIT];
        rx_threshold_select_reg   <= reg_wdata_i[RXC_SEL_LSB +: 2];
      end
      if (hit(reg_addr_i, OFS_DRAIN)) begin
        cable_power_drain_off_reg <= reg_wdata_i[DRN_VCONN_BIT];
        bus_power_drain_off_reg   <= reg_wdata_i[DRN_VBUS_BIT];
      end
      if (hit(reg_addr_i, OFS_THERMAL)) begin
        overheat_detect_on_reg <= reg_wdata_i[OT_EN_BIT];
      end
      if (hit(reg_addr_i, OFS_TIMER_LO)) begin
        tick_timer_low_reg <= reg_wdata_i;
      end
      if (timer_load) begin
        tick_timer_high_reg <= reg_wdata_i;
      end
    end
  end

  // Fast role swap request; a new write wins over the done pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frs_reg <= 1'b0;
    end else if (frs_set) begin
      frs_reg <= 1'b1;
    end else if (frs_done_i) begin
      frs_reg <= 1'b0;
    end
  end
  assign frs_send_o = frs_reg;

  // Carrier mode 2 sender; the mode bit is sampled live so it can end a run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bist_state_reg <= PDV_BIST_IDLE;
      bist_cnt_reg   <= '0;
    end else begin
      case (bist_state_reg)
        PDV_BIST_IDLE: begin
          bist_cnt_reg <= '0;
          if (bist_carrier_start_i) begin
            bist_state_reg <= PDV_BIST_SEND;
          end
        end
        PDV_BIST_SEND: begin
          bist_cnt_reg <= bist_cnt_reg + 1'b1;
          if (bist_carrier_stop_i) begin
            bist_state_reg <= PDV_BIST_IDLE;
          end else if (!carrier_continuous_reg && bist_cnt_reg >= BIST_LAST) begin
            bist_state_reg <= PDV_BIST_IDLE;
          end
        end
        default: bist_state_reg <= PDV_BIST_IDLE;
      endcase
    end
  end
  assign bist_carrier_o = (bist_state_reg == PDV_BIST_SEND);

  // Receive thresholds
  always_comb begin
    if (rx_threshold_override_reg) begin
      thresh_next.high = sel_high(rx_threshold_select_reg);
      thresh_next.low  = sel_low(rx_threshold_select_reg);
    end else if (power_role_source_i) begin
      thresh_next.high = PDV_LVL_SRC;
      thresh_next.low  = PDV_LVL_SRC;
    end else begin
      thresh_next.high = PDV_LVL_SNK;
      thresh_next.low  = PDV_LVL_SNK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thresh_reg <= '{high: PDV_LVL_SNK, low: PDV_LVL_SNK};
    end else begin
      thresh_reg <= thresh_next;
    end
  end
  assign rx_thresh_o = thresh_reg;

  // Receive status; a fresh preamble starts a new packet record
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_status_reg <= 4'h0;
    end else if (rx_event_i.preamble) begin
      rx_status_reg <= 4'h0;
      rx_status_reg[RXS_PRE_BIT] <= 1'b1;
      rx_status_reg[RXS_SOP_BIT] <= rx_event_i.sop;
    end else begin
      if (rx_event_i.sop) begin
        rx_status_reg[RXS_SOP_BIT] <= 1'b1;
      end
      if (rx_event_i.eop) begin
        rx_status_reg[RXS_EOP_BIT] <= 1'b1;
      end
      if (rx_event_i.crc_ok) begin
        rx_status_reg[RXS_CRC_BIT] <= 1'b1;
      end
    end
  end

  // Discharge switches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vbus_drain_reg  <= 1'b0;
      vconn_drain_reg <= 1'b0;
    end else begin
      vbus_drain_reg  <= vbus_drain_req_i && !bus_power_drain_off_reg;
      vconn_drain_reg <= vconn_drain_req_i && !cable_power_drain_off_reg;
    end
  end
  assign vbus_drain_o  = vbus_drain_reg;
  assign vconn_drain_o = vconn_drain_reg;

  // Detector pin is asynchronous; accept a level once two stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg        <= 1'b0;
      sync2_reg        <= 1'b0;
      sync3_reg        <= 1'b0;
      overheat_raw_reg <= 1'b0;
    end else begin
      sync1_reg <= overheat_detector_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        overheat_raw_reg <= sync3_reg;
      end
    end
  end
  assign overheat_live = overheat_raw_reg && overheat_detect_on_reg;

  // Latched overheat flag; detection wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overheat_latched_reg <= 1'b0;
    end else if (overheat_live) begin
      overheat_latched_reg <= 1'b1;
    end else if (status_clear_i[VST_OT_BIT]) begin
      overheat_latched_reg <= 1'b0;
    end
  end
  assign overheat_latched_o = overheat_latched_reg;

  // Millisecond tick timer
  assign tick            = (tick_cnt_reg == TICK_LAST);
  assign timer_hits_zero = (tmr_state_reg == PDV_TMR_RUN) && tick
                           && (tick_timer_value_reg == 16'h0001);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_state_reg        <= PDV_TMR_IDLE;
      tick_timer_value_reg <= 16'h0000;
      tick_cnt_reg         <= '0;
    end else if (timer_load) begin
      tick_timer_value_reg <= timer_load_value;
      tick_cnt_reg         <= '0;
      if (timer_load_value != 16'h0000) begin
        tmr_state_reg <= PDV_TMR_RUN;
      end else begin
        tmr_state_reg <= PDV_TMR_IDLE;
      end
    end else begin
      case (tmr_state_reg)
        PDV_TMR_RUN: begin
          tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
          if (tick) begin
            tick_timer_value_reg <= tick_timer_value_reg - 16'h0001;
          end
          if (timer_hits_zero) begin
            tmr_state_reg <= PDV_TMR_IDLE;
          end
        end
        PDV_TMR_IDLE: tick_cnt_reg <= '0;
        default:      tmr_state_reg <= PDV_TMR_IDLE;
      endcase
    end
  end

  // Expiry wins over a clear; reloading means no longer expired
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      expired_reg <= 1'b0;
    end else if (timer_hits_zero && !timer_load) begin
      expired_reg <= 1'b1;
    end else if (timer_load || status_clear_i[VST_TIMER_BIT]) begin
      expired_reg <= 1'b0;
    end
  end
  assign tick_timer_expired_o = expired_reg;

  // Read mux; timer bytes give back what was written, not the count
  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr_i)
      OFS_TX_CTRL: begin
        rdata_next[TXC_CONT_BIT] = carrier_continuous_reg;
        rdata_next[TXC_FRS_BIT]  = frs_reg;
      end
      OFS_RX_CTRL: begin
        rdata_next[RXC_RSV_BIT]         = rx_ctrl_spare_reg;
        rdata_next[RXC_OVR_BIT]         = rx_threshold_override_reg;
        rdata_next[RXC_SEL_LSB +: 2]    = rx_threshold_select_reg;
      end
      OFS_RX_STAT:  rdata_next[3:0] = rx_status_reg;
      OFS_DRAIN: begin
        rdata_next[DRN_VCONN_BIT] = cable_power_drain_off_reg;
        rdata_next[DRN_VBUS_BIT]  = bus_power_drain_off_reg;
      end
      OFS_THERMAL: begin
        rdata_next[OT_LIVE_BIT] = overheat_live;
        rdata_next[OT_EN_BIT]   = overheat_detect_on_reg;
      end
      OFS_TIMER_LO: rdata_next = tick_timer_low_reg;
      OFS_TIMER_HI: rdata_next = tick_timer_high_reg;
      default:      rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata_o = rdata_reg;

  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_frs_set_send: assert property (frs_set |=> frs_send_o)
    else $error("fast role swap not sent after write");
  a_frs_self_clear: assert property (frs_send_o && frs_done_i && !frs_set |=> !frs_send_o)
    else $error("fast role swap bit not cleared after send");
  a_bist_timed_end: assert property (
      bist_carrier_o && !carrier_continuous_reg && bist_cnt_reg >= BIST_LAST
      |=> !bist_carrier_o)
    else $error("timed carrier pattern overran");
  a_bist_cont_hold: assert property (
      bist_carrier_o && carrier_continuous_reg && !bist_carrier_stop_i
      |=> bist_carrier_o)
    else $error("continuous carrier pattern stopped");
  a_thresh_mixed: assert property (
      rx_threshold_override_reg && rx_threshold_select_reg == SEL_MIXED
      |=> rx_thresh_o.high == PDV_LVL_SNK && rx_thresh_o.low == PDV_LVL_SRC)
    else $error("mixed threshold selection wrong");
  a_thresh_role: assert property (
      !rx_threshold_override_reg && power_role_source_i
      |=> rx_thresh_o.low == PDV_LVL_SRC)
    else $error("threshold not taken from power role");
  a_rx_sop_seen: assert property (rx_event_i.sop |=> rx_status_reg[RXS_SOP_BIT])
    else $error("start of packet not recorded");
  a_rx_eop_seen: assert property (rx_event_i.eop && !rx_event_i.preamble
      |=> rx_status_reg[RXS_EOP_BIT])
    else $error("end of packet not recorded");
  a_vbus_drain_off: assert property (bus_power_drain_off_reg |=> !vbus_drain_o)
    else $error("internal bus drain used while disabled");
  a_vconn_drain_on: assert property (
      vconn_drain_req_i && !cable_power_drain_off_reg |=> vconn_drain_o)
    else $error("internal cable drain not used");
  a_ot_disabled: assert property (!overheat_detect_on_reg |-> !overheat_live)
    else $error("overheat detected while disabled");
  a_ot_latch_set: assert property (overheat_live |=> overheat_latched_o)
    else $error("overheat flag not latched");
  a_timer_load: assert property (timer_load && timer_load_value != 16'h0000
      |=> tmr_state_reg == PDV_TMR_RUN && tick_timer_value_reg == $past(timer_load_value))
    else $error("timer not started on non-zero load");
  a_timer_stop: assert property (timer_load && timer_load_value == 16'h0000
      |=> tmr_state_reg == PDV_TMR_IDLE && !tick_timer_expired_o)
    else $error("timer not stopped on zero load");
  a_timer_expire: assert property (timer_hits_zero && !timer_load
      |=> tick_timer_expired_o && tmr_state_reg == PDV_TMR_IDLE)
    else $error("timer expiry not flagged");
  a_lo_readback: assert property (reg_rd_i && reg_addr_i == OFS_TIMER_LO
      |=> reg_rdata_o == $past(tick_timer_low_reg))
    else $error("timer low byte readback wrong");
  a_lo_no_apply: assert property (reg_wr_i && reg_addr_i == OFS_TIMER_LO
      && tmr_state_reg == PDV_TMR_IDLE |=> $stable(tick_timer_value_reg))
    else $error("low byte write applied timer value");

  c_timer_expiry: cover property (timer_hits_zero);
  c_frs_cycle: cover property (frs_set ##[1:20] frs_done_i);
  c_bist_timed: cover property (bist_carrier_o && !carrier_continuous_reg ##1 !bist_carrier_o);
  c_overheat: cover property (overheat_live);

endmodule

/* tb/pdv_host_model.sv */
// Port manager model: strobed register writes and reads
module pdv_host_model (
  // Clock
  input  wire logic       clk_i,
  // Register bus
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    // Stale data would hide a missed strobe
    reg_wdata_o = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge clk_i);
    reg_rd_o   = 1'b0;
    d          = reg_rdata_i;
  endtask
endmodule

/* tb/tb_pd_phy_vendor_control_regs.sv */
// Register-level bench for the vendor register bank
module tb_pd_phy_vendor_control_regs;
  import pdv_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TICK_CYC = 10;
  localparam int BIST_CYC = 20;
  localparam int MAX_CYC  = 3000;

  logic             clk_i;
  logic             rst_i;
  logic [7:0]       addr;
  logic             wr;
  logic [7:0]       wdata;
  logic             rd;
  logic [7:0]       rdata;
  logic [14:0]      pls;
  logic             role_src;
  logic             vb_req;
  logic             vc_req;
  logic             ot_raw;
  logic             expired;
  logic             ot_latched;
  logic             bist;
  logic             frs;
  logic             vb_drain;
  logic             vc_drain;
  pdv_thresh_type   thr;
  int               n_errors;
  int               n_tests;
  int               cyc;
  int               n;
  logic [7:0]       offs[8] = '{OFS_TX_CTRL, OFS_RX_CTRL, OFS_RX_STAT, OFS_DRAIN,
                               OFS_THERMAL, OFS_TIMER_LO, OFS_TIMER_HI, 8'h9A};
  pdv_thresh_type   exp_t[4] = '{'{PDV_LVL_SNK, PDV_LVL_SNK}, '{PDV_LVL_SRC, PDV_LVL_SRC},
                                 '{PDV_LVL_NEU, PDV_LVL_NEU}, '{PDV_LVL_SNK, PDV_LVL_SRC}};

  pdv_host_model host_u (.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rdata_i(rdata));

  pdv_vendor_regs #(.TICK_CYCLES_P(TICK_CYC), .BIST_CYCLES_P(BIST_CYC)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .status_clear_i(pls[7:0]),
    .tick_timer_expired_o(expired), .overheat_latched_o(ot_latched),
    .bist_carrier_start_i(pls[13]), .bist_carrier_stop_i(pls[14]), .bist_carrier_o(bist),
    .frs_send_o(frs), .frs_done_i(pls[12]), .power_role_source_i(role_src),
    .rx_event_i(pdv_rx_event_type'(pls[11:8])), .rx_thresh_o(thr),
    .vbus_drain_req_i(vb_req), .vconn_drain_req_i(vc_req), .vbus_drain_o(vb_drain),
    .vconn_drain_o(vc_drain), .overheat_detector_i(ot_raw));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == MAX_CYC) begin
      n_errors++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask

  task automatic pulse(input logic [14:0] m);
    @(negedge clk_i);
    pls = m;
    @(negedge clk_i);
    pls = '0;
  endtask

  task automatic waitc(input int k);
    repeat (k) @(negedge clk_i);
  endtask

  task automatic test_end(input string nm);
    $display("test %s done", nm);
  endtask

  initial begin
    rst_i = 1'b1;
    pls = '0;
    role_src = 1'b1;
    vb_req = 1'b0;
    vc_req = 1'b0;
    ot_raw = 1'b0;
    waitc(16);
    rst_i = 1'b0;
    chk("thresh", 8'(exp_t[0]), 8'(thr));
    foreach (offs[i]) rchk(offs[i], 8'h00);
    test_end("reset");
    host_u.wr(8'h9A, 8'hFF);
    rchk(8'h9A, 8'h00);
    host_u.wr(OFS_RX_CTRL, 8'hFF);
    rchk(OFS_RX_CTRL, 8'h0F);
    host_u.wr(OFS_TX_CTRL, 8'hFD);
    rchk(OFS_TX_CTRL, 8'h04);
    host_u.wr(OFS_TIMER_LO, 8'h5A);
    rchk(OFS_TIMER_LO, 8'h5A);
    test_end("access");
    for (int s = 0; s < 4; s++) begin
      host_u.wr(OFS_RX_CTRL, 8'h04 | 8'(s));
      waitc(2);
      chk("thresh sel", 8'(exp_t[s]), 8'(thr));
    end
    host_u.wr(OFS_RX_CTRL, 8'h03);
    waitc(2);
    chk("thresh src", 8'(exp_t[1]), 8'(thr));
    role_src = 1'b0;
    waitc(2);
    chk("thresh snk", 8'(exp_t[0]), 8'(thr));
    test_end("thresholds");
    host_u.wr(OFS_TX_CTRL, 8'h02);
    waitc(1);
    chk("frs send", 8'h01, 8'(frs));
    rchk(OFS_TX_CTRL, 8'h02);
    pulse(15'h1000);
    waitc(2);
    chk("frs done", 8'h00, 8'(frs));
    rchk(OFS_TX_CTRL, 8'h00);
    test_end("fast swap");
    pulse(15'h2000);
    n = 0;
    while (bist === 1'b1 && n < 100) begin
      n++;
      waitc(1);
    end
    chk("bist timed", 8'(BIST_CYC), 8'(n));
    host_u.wr(OFS_TX_CTRL, 8'h04);
    pulse(15'h2000);
    waitc(3 * BIST_CYC);
    chk("bist cont", 8'h01, 8'(bist));
    pulse(15'h4000);
    waitc(2);
    chk("bist stop", 8'h00, 8'(bist));
    test_end("carrier");
    pulse(15'h0800);
    rchk(OFS_RX_STAT, 8'h08);
    pulse(15'h0400);
    rchk(OFS_RX_STAT, 8'h09);
    pulse(15'h0200);
    rchk(OFS_RX_STAT, 8'h0B);
    pulse(15'h0100);
    rchk(OFS_RX_STAT, 8'h0F);
    pulse(15'h0800);
    rchk(OFS_RX_STAT, 8'h08);
    test_end("rx status");
    vb_req = 1'b1;
    vc_req = 1'b1;
    for (int d = 0; d < 4; d++) begin
      host_u.wr(OFS_DRAIN, 8'(d));
      waitc(2);
      chk("vbus drain", 8'(!d[0]), 8'(vb_drain));
      chk("vconn drain", 8'(!d[1]), 8'(vc_drain));
    end
    vb_req = 1'b0;
    vc_req = 1'b0;
    host_u.wr(OFS_DRAIN, 8'h00);
    waitc(2);
    chk("drain idle", 8'h00, 8'({vb_drain, vc_drain}));
    test_end("discharge");
    ot_raw = 1'b1;
    waitc(8);
    rchk(OFS_THERMAL, 8'h00);
    chk("ot latched", 8'h00, 8'(ot_latched));
    host_u.wr(OFS_THERMAL, 8'hFF);
    waitc(8);
    rchk(OFS_THERMAL, 8'h11);
    chk("ot latched", 8'h01, 8'(ot_latched));
    ot_raw = 1'b0;
    waitc(8);
    rchk(OFS_THERMAL, 8'h01);
    chk("ot held", 8'h01, 8'(ot_latched));
    pulse(15'h0004);
    chk("ot clear", 8'h00, 8'(ot_latched));
    test_end("thermal");
    host_u.wr(OFS_TIMER_LO, 8'h03);
    host_u.wr(OFS_TIMER_HI, 8'h00);
    waitc(20);
    chk("tmr early", 8'h00, 8'(expired));
    rchk(OFS_TIMER_LO, 8'h03);
    rchk(OFS_TIMER_HI, 8'h00);
    waitc(10);
    chk("tmr expired", 8'h01, 8'(expired));
    pulse(15'h0010);
    chk("tmr clear", 8'h00, 8'(expired));
    host_u.wr(OFS_TIMER_LO, 8'h02);
    waitc(40);
    chk("tmr low only", 8'h00, 8'(expired));
    host_u.wr(OFS_TIMER_HI, 8'h00);
    waitc(10);
    host_u.wr(OFS_TIMER_LO, 8'h00);
    host_u.wr(OFS_TIMER_HI, 8'h00);
    waitc(40);
    chk("tmr stopped", 8'h00, 8'(expired));
    test_end("timer");
    final_report();
  end
endmodule
